// ==== hdl/e3lmr_params.svh ====
// register offsets, field positions, reset values and link constants
`ifndef E3LMR_PARAMS_SVH
`define E3LMR_PARAMS_SVH

// ============================================================
// register map (9-bit byte address)
`define E3LMR_ADDR_W 9
`define E3LMR_CTRL_ADDR 9'h018
`define E3LMR_STAT_ADDR 9'h019
`define E3LMR_BUF_FIRST 9'h0DE
`define E3LMR_BUF_LAST 9'h135
`define E3LMR_BUF_DEPTH 88

// ============================================================
// control register fields
`define E3LMR_CTRL_IRQ_STAT 0
`define E3LMR_CTRL_IRQ_EN 1
`define E3LMR_CTRL_ENABLE 2
`define E3LMR_CTRL_USE_NR 3
`define E3LMR_CTRL_RESET 8'h00

// ============================================================
// status register fields
`define E3LMR_STAT_FLAG 0
`define E3LMR_STAT_EOM 1
`define E3LMR_STAT_CHK_ERR 2
`define E3LMR_STAT_CR 3
`define E3LMR_STAT_TYPE_LO 4
`define E3LMR_STAT_TYPE_HI 5
`define E3LMR_STAT_ABORT 6
`define E3LMR_STAT_RESET 8'h00

// ============================================================
// link octets and check word
`define E3LMR_FLAG_OCTET 8'h7E
`define E3LMR_TYPE_TEST 8'h32
`define E3LMR_TYPE_IDLE 8'h34
`define E3LMR_TYPE_CL 8'h38
`define E3LMR_TYPE_ITU 8'h3F
`define E3LMR_CRC_POLY 16'h1021
`define E3LMR_CRC_INIT 16'hFFFF
`define E3LMR_CRC_GOOD 16'h1D0F
`define E3LMR_HDR_OCTETS 3
`define E3LMR_FCS_OCTETS 2
`define E3LMR_MIN_FRAME 8'h06
`define E3LMR_STUFF_ONES 3'h5
`define E3LMR_FLAG_ONES 3'h6
`define E3LMR_ABORT_ONES 3'h7
`define E3LMR_DELAY_BITS 3'h7

`endif

// ==== hdl/e3lmr_pkg.sv ====
// types shared by the link message receiver modules
package e3lmr_pkg;

  // ============================================================
  // deframer hunt state
  typedef enum logic {
    E3LMR_HUNT,
    E3LMR_IN_FRAME
  } e3lmr_hunt_e;

  // ============================================================
  // message type code as reported in status bits 5:4
  typedef logic [1:0] e3lmr_type_t;

endpackage : e3lmr_pkg

// ==== hdl/e3lmr_link_if.sv ====
// bit stream and octet events between the receiver and its deframer
`timescale 1ns/10ps
interface e3lmr_link_if;
  logic enable;
  logic bit_vld;
  logic bit_val;
  logic flag_stb;
  logic abort_stb;
  logic byte_stb;
  logic [7:0] byte_data;

  modport feed (output enable, output bit_vld, output bit_val,
                input flag_stb, input abort_stb, input byte_stb, input byte_data);
  modport deframer (input enable, input bit_vld, input bit_val,
                    output flag_stb, output abort_stb, output byte_stb, output byte_data);
endinterface : e3lmr_link_if

// ==== hdl/e3lmr_deframer.sv ====
// bit-level flag hunt, abort detection and zero destuffing
`timescale 1ns/10ps
`include "e3lmr_params.svh"
module e3lmr_deframer
  import e3lmr_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  e3lmr_link_if.deframer link
);

  // ============================================================
  // state
  e3lmr_hunt_e hunt_r, hunt_nxt;
  logic [2:0] ones_r, ones_nxt;
  logic [6:0] dly_r, dly_nxt;
  logic [2:0] fill_r, fill_nxt;
  logic [2:0] bcnt_r, bcnt_nxt;
  logic [7:0] asm_r, asm_nxt;
  logic flag_r, flag_nxt;
  logic abort_r, abort_nxt;
  logic byte_r, byte_nxt;

  // per-bit decode; a 7-bit delay hides the leading flag bits from the data path
  always_comb begin
    hunt_nxt = hunt_r;
    ones_nxt = ones_r;
    dly_nxt = dly_r;
    fill_nxt = fill_r;
    bcnt_nxt = bcnt_r;
    asm_nxt = asm_r;
    flag_nxt = 1'b0;
    abort_nxt = 1'b0;
    byte_nxt = 1'b0;
    if (!link.enable) begin
      hunt_nxt = E3LMR_HUNT; // disabled: hunting stops, nothing reported
      ones_nxt = 3'h0;
      fill_nxt = 3'h0;
      bcnt_nxt = 3'h0;
    end else if (link.bit_vld) begin
      if (link.bit_val) begin
        if (ones_r >= `E3LMR_FLAG_ONES) begin
          abort_nxt = 1'b1; // seventh one in a row
          ones_nxt = `E3LMR_ABORT_ONES; // saturate so the zero ending an abort is no flag
          hunt_nxt = E3LMR_HUNT;
          fill_nxt = 3'h0;
          bcnt_nxt = 3'h0;
        end else begin
          ones_nxt = ones_r + 3'h1;
        end
      end else begin
        ones_nxt = 3'h0;
      end
      if (!link.bit_val && ones_r == `E3LMR_FLAG_ONES) begin
        flag_nxt = 1'b1; // flag closes or opens a frame
        hunt_nxt = E3LMR_IN_FRAME;
        fill_nxt = 3'h0;
        bcnt_nxt = 3'h0;
      end else if (!link.bit_val && ones_r == `E3LMR_STUFF_ONES) begin
        ones_nxt = 3'h0; // stuffed zero dropped
      end else if (!(link.bit_val && ones_r >= `E3LMR_FLAG_ONES)) begin
        dly_nxt = {dly_r[5:0], link.bit_val};
        if (fill_r != `E3LMR_DELAY_BITS) begin
          fill_nxt = fill_r + 3'h1;
        end else if (hunt_r == E3LMR_IN_FRAME) begin
          asm_nxt = {asm_r[6:0], dly_r[6]};
          bcnt_nxt = bcnt_r + 3'h1;
          byte_nxt = (bcnt_r == 3'h7);
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hunt_r <= E3LMR_HUNT;
      ones_r <= 3'h0;
      dly_r <= 7'h00;
      fill_r <= 3'h0;
      bcnt_r <= 3'h0;
      asm_r <= 8'h00;
      flag_r <= 1'b0;
      abort_r <= 1'b0;
      byte_r <= 1'b0;
    end else begin
      hunt_r <= hunt_nxt;
      ones_r <= ones_nxt;
      dly_r <= dly_nxt;
      fill_r <= fill_nxt;
      bcnt_r <= bcnt_nxt;
      asm_r <= asm_nxt;
      flag_r <= flag_nxt;
      abort_r <= abort_nxt;
      byte_r <= byte_nxt;
    end
  end

  // event outputs
  assign link.flag_stb = flag_r;
  assign link.abort_stb = abort_r;
  assign link.byte_stb = byte_r;
  assign link.byte_data = asm_r;

endmodule : e3lmr_deframer

// ==== hdl/e3lmr_msg_ram.sv ====
// receive message buffer, one write port and one asynchronous read port
`timescale 1ns/10ps
module e3lmr_msg_ram #(
  parameter int DEPTH = 88,
  parameter int AW = 7
) (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [AW-1:0] rd_idx_i,
  output logic [7:0] rd_data_o
);

  // ============================================================
  // storage; no reset so it maps onto plain RAM
  logic [7:0] mem [0:DEPTH-1];

  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  // out-of-range reads answer zero
  assign rd_data_o = (int'(rd_idx_i) < DEPTH) ? mem[rd_idx_i] : 8'h00;

endmodule : e3lmr_msg_ram

// ==== hdl/e3lmr_top.sv ====
// link message receiver: octet select, frame tracking, check word and registers
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`include "e3lmr_params.svh"
module e3lmr_top
  import e3lmr_pkg::*;
#(
  parameter int BUF_DEPTH = `E3LMR_BUF_DEPTH
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic [7:0] GC_BYTE_I,
  input wire logic [7:0] NR_BYTE_I,
  input wire logic OH_BYTE_STB_I,
  input wire logic [`E3LMR_ADDR_W-1:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  output logic IRQ_O
);

  // buffer index width; the info index below stays 9 bits, so depths up to 250 fit
  localparam int AW = $clog2(BUF_DEPTH);

  // ============================================================
  // functions
  // MSB-first CRC-16 update, x16+x12+x5+1, one octet
  // bits enter most significant first, the order they come off the link
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ `E3LMR_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction : crc_step

  // type octet to status code; unknown codes fall back to test signal
  function automatic e3lmr_type_t type_code(input logic [7:0] t);
    case (t)
      `E3LMR_TYPE_IDLE: type_code = 2'b01;
      `E3LMR_TYPE_CL: type_code = 2'b10;
      `E3LMR_TYPE_ITU: type_code = 2'b11;
      default: type_code = 2'b00;
    endcase
  endfunction : type_code

  // ============================================================
  // registers
  // control bits
  logic use_nr_r, use_nr_nxt;
  logic enable_r, enable_nxt;
  logic irq_en_r, irq_en_nxt;
  logic irq_stat_r, irq_stat_nxt;
  // status bits
  logic flag_pres_r, flag_pres_nxt;
  logic eom_r, eom_nxt;
  logic chk_err_r, chk_err_nxt;
  logic cr_r, cr_nxt;
  e3lmr_type_t type_r, type_nxt;
  logic abort_r, abort_nxt;
  // read answer and interrupt line
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;

  // octet serialiser
  logic [7:0] ser_r, ser_nxt;
  logic [3:0] ser_cnt_r, ser_cnt_nxt;
  logic [7:0] sel_octet;

  // frame tracking
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] hold0_r, hold0_nxt;
  logic [7:0] hold1_r, hold1_nxt;
  logic [15:0] crc_r, crc_nxt;
  logic cr_cap_r, cr_cap_nxt;
  e3lmr_type_t type_cap_r, type_cap_nxt;

  // buffer port
  logic wr_en;
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [7:0] ram_rdata;
  logic [8:0] info_idx;
  logic [15:0] crc_upd;

  e3lmr_link_if link ();

  // ============================================================
  // deframer and message buffer
  e3lmr_deframer u_deframer (
    .clk_i(REF_CLK_I),
    .nrst_i(NRST_I),
    .link(link.deframer)
  );

  e3lmr_msg_ram #(
    .DEPTH(BUF_DEPTH),
    .AW(AW)
  ) u_msg_ram (
    .clk_i(REF_CLK_I),
    .wr_i(wr_en),
    .wr_idx_i(wr_idx),
    .wr_data_i(hold1_r),
    .rd_idx_i(rd_idx),
    .rd_data_o(ram_rdata)
  );

  // ============================================================
  // octet select and serialiser: eight clocks per octet, far quicker than the frame rate
  assign sel_octet = use_nr_r ? NR_BYTE_I : GC_BYTE_I;

  // strobes come at least nine clocks apart, so an octet is always fully shifted out
  always_comb begin
    ser_nxt = ser_r;
    ser_cnt_nxt = ser_cnt_r;
    flag_pres_nxt = flag_pres_r;
    if (enable_r && OH_BYTE_STB_I) begin
      ser_nxt = sel_octet;
      ser_cnt_nxt = 4'h8;
      flag_pres_nxt = (sel_octet == `E3LMR_FLAG_OCTET);
    end else if (ser_cnt_r != 4'h0) begin
      ser_nxt = {ser_r[6:0], 1'b0};
      ser_cnt_nxt = ser_cnt_r - 4'h1;
    end
    if (!enable_r) begin
      ser_cnt_nxt = 4'h0; // held idle until software enables
    end
  end

  assign link.enable = enable_r;
  assign link.bit_vld = (ser_cnt_r != 4'h0) && enable_r;
  assign link.bit_val = ser_r[7];

  // ============================================================
  // frame tracking: two octets held back so the check octets never reach the buffer
  assign crc_upd = crc_step(crc_r, link.byte_data);
  // header octets and the two held-back octets come first
  assign info_idx = {1'b0, cnt_r} - 9'd5;
  // info octets past the buffer end are dropped, never wrapped onto the type octet
  assign wr_en = link.byte_stb && cnt_r >= 8'd5 && int'(info_idx) < BUF_DEPTH;
  assign wr_idx = info_idx[AW-1:0];

  always_comb begin
    cnt_nxt = cnt_r;
    hold0_nxt = hold0_r;
    hold1_nxt = hold1_r;
    crc_nxt = crc_r;
    cr_cap_nxt = cr_cap_r;
    type_cap_nxt = type_cap_r;
    if (link.flag_stb || link.abort_stb) begin
      cnt_nxt = 8'h00; // repeated flags simply restart the count
      crc_nxt = `E3LMR_CRC_INIT;
    end else if (link.byte_stb) begin
      crc_nxt = crc_upd; // covers header, message and check octets
      hold0_nxt = link.byte_data;
      hold1_nxt = hold0_r;
      if (cnt_r != 8'hFF) begin
        cnt_nxt = cnt_r + 8'h01;
      end
      if (cnt_r == 8'h00) begin
        cr_cap_nxt = link.byte_data[1];
      end
      if (cnt_r == 8'h05) begin
        type_cap_nxt = type_code(hold1_r); // first message octet
      end
    end
  end

  // ============================================================
  // address decode, shared by the write and read paths
  logic ctrl_sel;
  logic stat_sel;
  logic buf_sel;
  assign ctrl_sel = (ADDR_I == `E3LMR_CTRL_ADDR);
  assign stat_sel = (ADDR_I == `E3LMR_STAT_ADDR);
  assign buf_sel = (ADDR_I >= `E3LMR_BUF_FIRST) && (ADDR_I <= `E3LMR_BUF_LAST);

  // ============================================================
  // status and control registers, software access
  always_comb begin
    use_nr_nxt = use_nr_r;
    enable_nxt = enable_r;
    irq_en_nxt = irq_en_r;
    irq_stat_nxt = irq_stat_r;
    eom_nxt = eom_r;
    chk_err_nxt = chk_err_r;
    cr_nxt = cr_r;
    type_nxt = type_r;
    abort_nxt = abort_r;
    rdata_nxt = 8'h00;
    // offset from the low address bits; outside the window the answer is masked anyway
    rd_idx = ADDR_I[AW-1:0] - AW'(`E3LMR_BUF_FIRST);
    if (WR_I && ctrl_sel) begin
      use_nr_nxt = WDATA_I[`E3LMR_CTRL_USE_NR];
      enable_nxt = WDATA_I[`E3LMR_CTRL_ENABLE];
      irq_en_nxt = WDATA_I[`E3LMR_CTRL_IRQ_EN];
    end
    if (RD_I) begin
      if (ctrl_sel) begin
        rdata_nxt = {4'h0, use_nr_r, enable_r, irq_en_r, irq_stat_r};
        irq_stat_nxt = 1'b0; // cleared by the read
      end else if (stat_sel) begin
        rdata_nxt = {1'b0, abort_r, type_r, cr_r, chk_err_r, eom_r, flag_pres_r};
      end else if (buf_sel) begin
        rdata_nxt = ram_rdata;
      end
    end
    if (link.abort_stb) begin
      abort_nxt = 1'b1;
    end
    // shorter runs between flags are not reported, though their first octet still clears eom
    if (link.flag_stb && cnt_r >= `E3LMR_MIN_FRAME) begin
      chk_err_nxt = (crc_r != `E3LMR_CRC_GOOD);
      cr_nxt = cr_cap_r;
      type_nxt = type_cap_r;
      eom_nxt = 1'b1;
      abort_nxt = 1'b0;
      irq_stat_nxt = 1'b1; // set wins over the read clear
    end else if (link.byte_stb && cnt_r == 8'h00) begin
      eom_nxt = 1'b0; // new frame under way
    end
    // built from next values so the line follows a read or write with no extra lag
    irq_nxt = irq_stat_nxt && irq_en_nxt;
  end

  // one register stage for all groups; every flop runs on every edge
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      use_nr_r <= 1'b0;
      enable_r <= 1'b0;
      irq_en_r <= 1'b0;
      irq_stat_r <= 1'b0;
      flag_pres_r <= 1'b0;
      eom_r <= 1'b0;
      chk_err_r <= 1'b0;
      cr_r <= 1'b0;
      type_r <= 2'b00;
      abort_r <= 1'b0;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      ser_r <= 8'h00;
      ser_cnt_r <= 4'h0;
      cnt_r <= 8'h00;
      hold0_r <= 8'h00;
      hold1_r <= 8'h00;
      crc_r <= `E3LMR_CRC_INIT;
      cr_cap_r <= 1'b0;
      type_cap_r <= 2'b00;
    end else begin
      use_nr_r <= use_nr_nxt;
      enable_r <= enable_nxt;
      irq_en_r <= irq_en_nxt;
      irq_stat_r <= irq_stat_nxt;
      flag_pres_r <= flag_pres_nxt;
      eom_r <= eom_nxt;
      chk_err_r <= chk_err_nxt;
      cr_r <= cr_nxt;
      type_r <= type_nxt;
      abort_r <= abort_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      ser_r <= ser_nxt;
      ser_cnt_r <= ser_cnt_nxt;
      cnt_r <= cnt_nxt;
      hold0_r <= hold0_nxt;
      hold1_r <= hold1_nxt;
      crc_r <= crc_nxt;
      cr_cap_r <= cr_cap_nxt;
      type_cap_r <= type_cap_nxt;
    end
  end

  // outputs straight from flops
  assign RDATA_O = rdata_r;
  assign IRQ_O = irq_r;

endmodule : e3lmr_top

// ==== testbench/e3lmr_far_end.sv ====
// far-end link transmitter model: one overhead octet per e3 frame
`timescale 1ns/10ps
module e3lmr_far_end (
  input wire logic clk_i,
  input wire logic use_nr_i,
  output logic [7:0] gc_o = 8'h00,
  output logic [7:0] nr_o = 8'h00,
  output logic stb_o = 1'b0
);
  // ==========
  // serial bit queue, msb first
  logic bq[$];
  logic [7:0] oct;
  int ones = 0;
  int gap = 0;

  // zero goes in after five ones so data never looks like a flag
  task automatic put(input logic [7:0] b, input logic stuff);
    for (int i = 7; i >= 0; i--) begin
      bq.push_back(b[i]);
      ones = (stuff && b[i]) ? ones + 1 : 0;
      if (ones == 5) begin
        bq.push_back(1'b0);
        ones = 0;
      end
    end
  endtask : put

  // flag, octets, inverted crc msb first, flag; bad flips bit 0 of the check word
  task automatic send_frame(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = 16'hFFFF;
    ones = 0;
    put(8'h7E, 1'b0);
    foreach (f[k]) begin
      put(f[k], 1'b1);
      for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ f[k][i]) ? 16'h1021 : 16'h0000);
    end
    c = ~c ^ {15'h0000, bad};
    put(c[15:8], 1'b1);
    put(c[7:0], 1'b1);
    put(8'h7E, 1'b0);
    while (bq.size() % 8 != 0) bq.push_back(1'b0); // pad so idle flags land on whole octets
  endtask : send_frame

  // ==========
  // one octet every ten cycles; idle fill is flags, unused byte inverted
  always @(posedge clk_i) begin
    gap <= (gap == 9) ? 0 : gap + 1;
    stb_o <= (gap == 9);
    if (gap == 9) begin
      if (bq.size() < 8) put(8'h7E, 1'b0);
      for (int i = 7; i >= 0; i--) oct[i] = bq.pop_front();
      gc_o <= use_nr_i ? ~oct : oct;
      nr_o <= use_nr_i ? oct : ~oct;
    end
  end
endmodule : e3lmr_far_end

// ==== testbench/e3lmr_top_props.sv ====
// concurrent checks on the receiver register port and interrupt
`timescale 1ns/10ps
`include "e3lmr_params.svh"
module e3lmr_top_props #(
  parameter int BUF_DEPTH = 88
) (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic OH_BYTE_STB_I,
  input wire logic [`E3LMR_ADDR_W-1:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic IRQ_O
);
  // ==========
  // shadow of control bits 3:1 and cycles since the last octet strobe
  logic [2:0] ctl_r;
  logic [2:0] ctl_nxt;
  logic [7:0] since_r;
  logic [7:0] since_nxt;
  logic ctl_rd;
  logic ctl_wr;
  logic unmapped;
  assign ctl_rd = RD_I && ADDR_I == `E3LMR_CTRL_ADDR;
  assign ctl_wr = WR_I && ADDR_I == `E3LMR_CTRL_ADDR;
  assign unmapped = (ADDR_I > `E3LMR_STAT_ADDR && ADDR_I < `E3LMR_BUF_FIRST) || ADDR_I >= `E3LMR_BUF_FIRST + BUF_DEPTH;

  // counter saturates so a long idle never wraps into a false match
  always_comb begin
    ctl_nxt = ctl_wr ? WDATA_I[3:1] : ctl_r;
    since_nxt = OH_BYTE_STB_I ? 8'h00 : since_r + {7'h00, since_r != 8'hFF};
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctl_r <= 3'h0;
      since_r <= 8'hFF;
    end else begin
      ctl_r <= ctl_nxt;
      since_r <= since_nxt;
    end
  end

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);

  // ==========
  // register port answers
  a_rdata_idle_zero: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data not zero outside a read answer");
  a_ctrl_read_back: assert property (ctl_rd |=> RDATA_O[7:1] == {4'h0, $past(ctl_r)})
    else $error("control read does not match written bits");
  a_stat_top_zero: assert property (RD_I && ADDR_I == `E3LMR_STAT_ADDR |=> !RDATA_O[7])
    else $error("status bit 7 not zero");
  a_unmapped_read_zero: assert property (RD_I && unmapped |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");

  // ==========
  // interrupt line
  a_irq_needs_enable: assert property (IRQ_O |-> ctl_r[0] || $past(ctl_r[0]))
    else $error("interrupt without interrupt enable");
  a_irq_read_clear: assert property (ctl_rd |=> !IRQ_O)
    else $error("interrupt still high after control read");
  a_irq_holds_level: assert property (IRQ_O && !ctl_rd && !ctl_wr |=> IRQ_O)
    else $error("interrupt dropped without read");
  a_irq_after_frame: assert property ($rose(IRQ_O) && !$past(WR_I) && !$past(WR_I, 2) |-> since_r < 8'd24)
    else $error("interrupt rose far from any octet");
endmodule : e3lmr_top_props

bind e3lmr_top e3lmr_top_props #(.BUF_DEPTH(BUF_DEPTH)) u_props (
  .REF_CLK_I(REF_CLK_I),
  .NRST_I(NRST_I),
  .OH_BYTE_STB_I(OH_BYTE_STB_I),
  .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I),
  .WR_I(WR_I),
  .RD_I(RD_I),
  .RDATA_O(RDATA_O),
  .IRQ_O(IRQ_O)
);

// ==== testbench/tb_top.sv ====
// self-checking bench for the link message receiver
`timescale 1ns/10ps
`include "e3lmr_params.svh"
module tb_top;
  // ==========
  // clock, register port and scoreboard
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic use_nr = 1'b0;
  logic pend = 1'b0;
  logic [7:0] gc;
  logic [7:0] nr;
  logic [7:0] rdata;
  logic stb;
  logic irq;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  logic [7:0] f[$];
  logic [7:0] tys[4];
  logic [31:0] rng = 32'd1624;
  int n_errors = 0;
  int n_compared = 0;

  always #4 clk = ~clk;

  e3lmr_far_end far (.clk_i(clk), .use_nr_i(use_nr), .gc_o(gc), .nr_o(nr), .stb_o(stb));
  e3lmr_top DUT (.REF_CLK_I(clk), .NRST_I(nrst), .GC_BYTE_I(gc), .NR_BYTE_I(nr), .OH_BYTE_STB_I(stb),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // strobes are left up so back-to-back cycles never assign twice in one step
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [8:0] a, input logic [7:0] e, input logic [7:0] m);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
  endtask : rd_reg

  task automatic idle;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : idle

  task automatic drain;
    for (int i = 0; i < 3000 && far.bq.size() != 0; i++) @(posedge clk);
    repeat (40) @(posedge clk);
  endtask : drain

  // header, type octet, random body with a flag and an all-ones octet to force stuffing
  task automatic mk(input logic [7:0] a1, input logic [7:0] ty, input int len);
    f = {a1, 8'h01, 8'h03, ty};
    for (int k = 1; k < len; k++) begin
      rng = xs(rng);
      f.push_back(k == 5 ? 8'h7E : (k == 6 ? 8'hFF : rng[7:0]));
    end
  endtask : mk

  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // ==========
  // answer is sampled mid-cycle, one cycle after the strobe
  always @(negedge clk) begin
    if (pend) begin
      n_compared++;
      if ((rdata & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
        n_errors++;
        $display("ERROR %0t got %h exp %h", $time, rdata, exp_q[0]);
      end
      exp_q.delete(0);
      msk_q.delete(0);
    end
    pend = rd;
  end

  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  // ==========
  // scenarios
  initial begin
    tys = '{`E3LMR_TYPE_TEST, `E3LMR_TYPE_IDLE, `E3LMR_TYPE_CL, `E3LMR_TYPE_ITU};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_reg(`E3LMR_CTRL_ADDR, 8'h00, 8'hFF);
    idle();
    mk(8'h3C, tys[0], 76);
    far.send_frame(f, 1'b0);
    drain();
    rd_reg(`E3LMR_STAT_ADDR, 8'h00, 8'hFF);
    wr_reg(`E3LMR_STAT_ADDR, 8'hFF);
    rd_reg(9'h01A, 8'h00, 8'hFF);
    rd_reg(9'h136, 8'h00, 8'hFF);
    wr_reg(`E3LMR_CTRL_ADDR, 8'h06);
    rd_reg(`E3LMR_CTRL_ADDR, 8'h06, 8'hFF);
    idle();
    repeat (40) @(posedge clk);
    rd_reg(`E3LMR_STAT_ADDR, 8'h01, 8'hFF);
    for (int t = 0; t < 4; t++) begin
      use_nr <= t[0];
      wr_reg(`E3LMR_CTRL_ADDR, {4'h0, t[0], 3'h6});
      idle();
      mk(t[1] ? 8'h3E : 8'h3C, tys[t], t == 3 ? 82 : 76);
      far.send_frame(f, t == 2);
      repeat (300) @(posedge clk);
      rd_reg(`E3LMR_STAT_ADDR, 8'h00, 8'h01);
      idle();
      for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk);
      n_compared++;
      if (irq !== 1'b1) begin
        n_errors++;
        $display("ERROR %0t got %h exp %h", $time, irq, 1'b1);
      end
      rd_reg(`E3LMR_STAT_ADDR, {2'b00, t[1:0], t[1], t == 2, 2'b10}, 8'h7E);
      rd_reg(`E3LMR_CTRL_ADDR, {4'h0, t[0], 3'h7}, 8'hFF);
      rd_reg(`E3LMR_CTRL_ADDR, {4'h0, t[0], 3'h6}, 8'hFF);
      for (int k = 0; k < f.size() - 3; k++) rd_reg(9'(`E3LMR_BUF_FIRST + k), f[k + 3], 8'hFF);
      idle();
    end
    far.put(8'h7E, 1'b0);
    far.put(8'hFF, 1'b0);
    far.put(8'hFF, 1'b0);
    drain();
    rd_reg(`E3LMR_STAT_ADDR, 8'h40, 8'h40);
    wr_reg(`E3LMR_CTRL_ADDR, 8'h02);
    idle();
    mk(8'h3C, tys[0], 76);
    far.send_frame(f, 1'b1);
    drain();
    rd_reg(`E3LMR_STAT_ADDR, 8'h78, 8'h7C);
    rd_reg(`E3LMR_BUF_FIRST, `E3LMR_TYPE_ITU, 8'hFF);
    rd_reg(`E3LMR_CTRL_ADDR, 8'h02, 8'hFE);
    idle();
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule : tb_top
